// [core/csie_stack_irq.v]
// Functional notes
// RULE1 - Stack grows downward; pointer always marks current top.
// RULE2 - Byte push subtracts one from pointer; byte pop adds one.
// RULE3 - Subroutine calls and interrupt entry push return address, pointer minus two.
// RULE4 - Subroutine and interrupt returns pop return address, pointer plus two.
// RULE5 - Pointer kept as low and high byte registers in I/O space.
// RULE6 - Reset loads last SRAM address; software sets pointer before enabling.
// RULE7 - Core runs straight from the chip clock, no division.
// RULE8 - Source served only when own enable and global enable are set.
// RULE9 - Boot lock bits may suppress interrupts depending on program counter.
// RULE10 - Lower vector wins; reset highest, external request zero next.
// RULE11 - Vector select bit relocates vectors; boot fuse relocates reset vector.
// RULE12 - Entry clears global enable; software may set it for nesting.
// RULE13 - Vectoring clears flag; writing one to flag also clears it.
// RULE14 - Flags latched while globally disabled, served later by priority.
// RULE15 - Level requests act only while condition is present, no latch.
// RULE16 - After interrupt return one main instruction runs before next interrupt.
// RULE17 - Global disable acts at once, even on simultaneous request.
// RULE18 - After global enable the next instruction runs before pending interrupts.
// RULE19 - Entry takes four cycles pushing program counter before vector.
// RULE20 - Multi-cycle instruction finishes before interrupt entry starts.
// RULE21 - Interrupt in sleep adds four cycles to entry.
// RULE22 - Return takes four cycles, pops PC, pointer plus two, sets enable.
// RULE23 - Global enable is status bit seven; zero blocks every interrupt.
// RULE24 - Push writes then decrements; pop increments then reads.
`include "csie_map.vh"
module csie_stack_irq (
   clk,
   resetn,
   ioAddr,
   ioWrite,
   ioRead,
   ioWdata,
   ioRdata,
   opPush,
   opPop,
   opCall,
   opRet,
   opReti,
   opSei,
   opCli,
   instrBoundary,
   sleeping,
   curPc,
   pushData,
   popData,
   irqEvent,
   irqLevel,
   irqIsLevel,
   irqEnable,
   appLockBitB,
   bootLockBitB,
   bootResetVectorFuse,
   inBootSection,
   stackAddr,
   stackWe,
   stackRe,
   stackWdata,
   entryBusy,
   vectorValid,
   vectorAddr,
   resetVector,
   retPcValid,
   retPc,
   irqFlags,
   globalEnable,
   stackPointer
);
   input  wire        clk;
   input  wire        resetn;
   input  wire [5:0]  ioAddr;
   input  wire        ioWrite;
   input  wire        ioRead;
   input  wire [7:0]  ioWdata;
   output reg  [7:0]  ioRdata;
   input  wire        opPush;
   input  wire        opPop;
   input  wire        opCall;
   input  wire        opRet;
   input  wire        opReti;
   input  wire        opSei;
   input  wire        opCli;
   input  wire        instrBoundary;
   input  wire        sleeping;
   input  wire [15:0] curPc;
   input  wire [7:0]  pushData;
   input  wire [7:0]  popData;
   input  wire [7:0]  irqEvent;
   input  wire [7:0]  irqLevel;
   input  wire [7:0]  irqIsLevel;
   input  wire [7:0]  irqEnable;
   input  wire        appLockBitB;
   input  wire        bootLockBitB;
   input  wire        bootResetVectorFuse;
   input  wire        inBootSection;
   output reg  [15:0] stackAddr;
   output reg         stackWe;
   output reg         stackRe;
   output reg  [7:0]  stackWdata;
   output wire        entryBusy;
   output reg         vectorValid;
   output reg  [15:0] vectorAddr;
   output wire [15:0] resetVector;
   output reg         retPcValid;
   output reg  [15:0] retPc;
   output wire [7:0]  irqFlags;
   output wire        globalEnable;
   output wire [15:0] stackPointer;

   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   localparam [4:0] ST_IDLE  = 5'h01;
   localparam [4:0] ST_WAKE  = 5'h02;
   localparam [4:0] ST_ENTRY = 5'h04;
   localparam [4:0] ST_ISR_EXIT_OP  = 5'h08;
   localparam [4:0] ST_RET   = 5'h10;

   reg [4:0]  state_reg;
   reg [4:0]  state_next;
   reg [2:0]  cnt_reg;
   reg [2:0]  cnt_next;
   reg [15:0] sp_reg;
   reg [15:0] sp_next;
   reg        gie_reg;
   reg        gie_next;
   reg        vector_relocate_sel_reg;
   reg [7:0]  flag_reg;
   reg [7:0]  flag_next;
   reg        holdOff_reg;
   reg        holdOff_next;
   reg [2:0]  pick_reg;
   reg [15:0] savePc_reg;
   reg [15:0] savePc_next;
   reg [7:0]  retLow_reg;
   reg        isReti_reg;
   reg        isReti_next;

   wire [7:0] reqVec;
   wire       grantValid;
   wire [2:0] grantIdx;
   wire       lockBlock;
   wire       takeIrq;
   wire [15:0] vecBase;
   reg  [2:0] pick_next;

   assign globalEnable = gie_reg;
   assign stackPointer = sp_reg;
   assign irqFlags     = flag_reg;
   assign entryBusy    = (state_reg != ST_IDLE);
   // RULE7: plain clk drives every register, no divider
   // ------------------------------------------------------------
   // Request gating
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `CSIE_NUM_IRQ; g = g + 1) begin : gReq
         // Level sources bypass the latch; flags hold until served
         assign reqVec[g] = irqEnable[g] &                          // RULE8
                            (irqIsLevel[g] ? irqLevel[g] : flag_reg[g]); // RULE15 RULE14
      end
   endgenerate

   csie_irq_arbiter uArb (
      .req        (reqVec),
      .grantValid (grantValid),
      .grantIdx   (grantIdx)
   );

   // App lock bit blocks outside the boot section, boot lock bit blocks inside it
   assign lockBlock = (appLockBitB & ~inBootSection) |
                      (bootLockBitB & inBootSection);  // RULE9

   // Cli in the same cycle wins over any request
   assign takeIrq = grantValid & gie_reg & ~opCli & ~holdOff_reg & ~lockBlock &
                    instrBoundary & (state_reg == ST_IDLE); // RULE8 RULE17 RULE20 RULE23

   assign vecBase     = vector_relocate_sel_reg ? `CSIE_BOOT_START : 16'h0000; // RULE11
   assign resetVector = bootResetVectorFuse ? `CSIE_BOOT_START : 16'h0000; // RULE11

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always @* begin
      state_next   = state_reg;
      cnt_next     = cnt_reg;
      sp_next      = sp_reg;
      gie_next     = gie_reg;
      flag_next    = flag_reg;
      holdOff_next = 1'b0;
      pick_next    = pick_reg;
      savePc_next  = savePc_reg;
      isReti_next  = isReti_reg;
      stackAddr    = sp_reg;
      stackWe      = 1'b0;
      stackRe      = 1'b0;
      stackWdata   = 8'h00;
      if (instrBoundary && holdOff_reg == 1'b0) begin
         holdOff_next = 1'b0;
      end
      case (state_reg)
         ST_IDLE: begin
            if (takeIrq) begin
               pick_next   = grantIdx;                               // RULE10
               savePc_next = curPc;
               gie_next    = 1'b0;                                   // RULE12
               cnt_next    = 3'h1;
               state_next  = sleeping ? ST_WAKE : ST_ENTRY;          // RULE21
            end else if (opPush) begin
               stackAddr  = sp_reg;                                  // RULE24
               stackWe    = 1'b1;
               stackWdata = pushData;
               sp_next    = sp_reg - 16'h0001;                       // RULE1 RULE2
            end else if (opPop) begin
               sp_next   = sp_reg + 16'h0001;                        // RULE2
               stackAddr = sp_reg + 16'h0001;                        // RULE24
               stackRe   = 1'b1;
            end else if (opCall) begin
               savePc_next = curPc;
               cnt_next    = 3'h1;
               state_next  = ST_ENTRY;                               // RULE3
               pick_next   = 3'h0;
               isReti_next = 1'b1;
            end else if (opRet || opReti) begin
               cnt_next    = 3'h1;
               isReti_next = opReti;
               state_next  = ST_ISR_EXIT_OP;                                // RULE4
            end
            if (opCli) begin
               gie_next = 1'b0;                                      // RULE17
            end else if (opSei) begin
               gie_next     = 1'b1;
               holdOff_next = ~gie_reg;                              // RULE18
            end
         end
         ST_WAKE: begin
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == `CSIE_WAKE_CYCLES) begin
               cnt_next   = 3'h1;
               state_next = ST_ENTRY;                                // RULE21
            end
         end
         ST_ENTRY: begin
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h1) begin
               stackAddr  = sp_reg;
               stackWe    = 1'b1;
               stackWdata = savePc_reg[7:0];
               sp_next    = sp_reg - 16'h0001;                       // RULE3
            end else if (cnt_reg == 3'h2) begin
               stackAddr  = sp_reg;
               stackWe    = 1'b1;
               stackWdata = savePc_reg[15:8];
               sp_next    = sp_reg - 16'h0001;                       // RULE3
            end else if (cnt_reg == `CSIE_ENTRY_CYCLES) begin
               state_next  = ST_IDLE;                                // RULE19
               isReti_next = 1'b0;
               if (!isReti_reg && !irqIsLevel[pick_reg]) begin
                  flag_next[pick_reg] = 1'b0;                        // RULE13
               end
            end
         end
         ST_ISR_EXIT_OP: begin
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h1 || cnt_reg == 3'h2) begin
               stackAddr = sp_reg + 16'h0001;
               stackRe   = 1'b1;
               sp_next   = sp_reg + 16'h0001;                        // RULE4 RULE22
            end else if (cnt_reg == `CSIE_ISR_EXIT_OP_CYCLES) begin
               state_next = ST_IDLE;
               if (isReti_reg) begin
                  gie_next     = 1'b1;                               // RULE22
                  holdOff_next = 1'b1;                               // RULE16
               end
               isReti_next = 1'b0;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      if (state_reg != ST_IDLE && holdOff_reg) begin
         holdOff_next = 1'b1;
      end
      if (ioWrite && ioAddr == `CSIE_SP_LOW_ADDR) begin
         sp_next[7:0] = ioWdata;                                     // RULE5
      end
      if (ioWrite && ioAddr == `CSIE_SP_HIGH_ADDR) begin
         sp_next[15:8] = ioWdata;                                    // RULE5
      end
      if (ioWrite && ioAddr == `CSIE_STATUS_ADDR) begin
         gie_next = ioWdata[`CSIE_GIE_BIT];                          // RULE12 RULE23
      end
      // Software clear by writing one; new event wins over the clear
      if (ioWrite && ioAddr == `CSIE_CORECTL_ADDR + 6'h01) begin
         flag_next = flag_next & ~ioWdata;                           // RULE13
      end
      flag_next = flag_next | (irqEvent & ~irqIsLevel);              // RULE14
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (!resetn) begin
         state_reg   <= ST_IDLE;
         cnt_reg     <= 3'h0;
         sp_reg      <= `CSIE_SP_RESET;                              // RULE6
         gie_reg     <= 1'b0;
         vector_relocate_sel_reg   <= 1'b0;
         flag_reg    <= 8'h00;
         holdOff_reg <= 1'b0;
         pick_reg    <= 3'h0;
         savePc_reg  <= 16'h0000;
         retLow_reg  <= 8'h00;
         isReti_reg  <= 1'b0;
         vectorValid <= 1'b0;
         vectorAddr  <= 16'h0000;
         retPcValid  <= 1'b0;
         retPc       <= 16'h0000;
      end else begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         sp_reg      <= sp_next;
         gie_reg     <= gie_next;
         flag_reg    <= flag_next;
         holdOff_reg <= holdOff_next;
         pick_reg    <= pick_next;
         savePc_reg  <= savePc_next;
         isReti_reg  <= isReti_next;
         if (ioWrite && ioAddr == `CSIE_CORECTL_ADDR) begin
            vector_relocate_sel_reg <= ioWdata[`CSIE_VECSEL_BIT];                  // RULE11
         end
         // Vector slot two words apart; slot zero is reset
         vectorValid <= (state_reg == ST_ENTRY) && (cnt_reg == `CSIE_ENTRY_CYCLES)
                        && !isReti_reg;                              // RULE19
         // Four-bit slot index so the last source does not wrap onto reset
         vectorAddr  <= vecBase + {11'h000, {1'b0, pick_reg} + 4'h1, 1'b0}; // RULE10
         if (state_reg == ST_ISR_EXIT_OP && cnt_reg == 3'h2) begin
            retLow_reg <= popData;
         end
         retPcValid <= (state_reg == ST_ISR_EXIT_OP) && (cnt_reg == 3'h3);
         if (state_reg == ST_ISR_EXIT_OP && cnt_reg == 3'h3) begin
            retPc <= {retLow_reg, popData};                          // RULE22
         end
      end
   end

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------
   always @* begin
      ioRdata = 8'h00;
      if (ioRead) begin
         case (ioAddr)
            `CSIE_SP_LOW_ADDR:  ioRdata = sp_reg[7:0];               // RULE5
            `CSIE_SP_HIGH_ADDR: ioRdata = sp_reg[15:8];              // RULE5
            `CSIE_STATUS_ADDR:  ioRdata = {gie_reg, 7'h00};
            `CSIE_CORECTL_ADDR: ioRdata = {6'h00, vector_relocate_sel_reg, 1'b0};
            default:            ioRdata = flag_reg;
         endcase
      end
   end
endmodule // csie_stack_irq

// [core/csie_map.vh]
`ifndef CSIE_MAP_VH
`define CSIE_MAP_VH
// ------------------------------------------------------------
// Register offsets (I/O space)
// ------------------------------------------------------------
`define CSIE_SP_LOW_ADDR   6'h3D
`define CSIE_SP_HIGH_ADDR  6'h3E
`define CSIE_STATUS_ADDR   6'h3F
`define CSIE_CORECTL_ADDR  6'h35
// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define CSIE_GIE_BIT       7
`define CSIE_VECSEL_BIT    1
`define CSIE_SP_RESET      16'h04FF
`define CSIE_BOOT_START    16'h1C00
`define CSIE_NUM_IRQ       8
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CSIE_ENTRY_CYCLES  3'h4
`define CSIE_ISR_EXIT_OP_CYCLES   3'h4
`define CSIE_WAKE_CYCLES   3'h4
`endif

// [core/csie_irq_arbiter.v]
// ------------------------------------------------------------
// Fixed priority pick, lowest index wins
// ------------------------------------------------------------
module csie_irq_arbiter (
   req,
   grantValid,
   grantIdx
);
   input  wire [7:0] req;
   output reg        grantValid;
   output reg  [2:0] grantIdx;
   integer i;
   always @* begin
      grantValid = 1'b0;
      grantIdx   = 3'h0;
      for (i = 7; i >= 0; i = i - 1) begin
         if (req[i]) begin
            grantValid = 1'b1;
            grantIdx   = i[2:0];
         end
      end
   end
endmodule // csie_irq_arbiter

// [dv/csie_stack_ram.sv]
module csie_stack_ram (
   input  wire        clk,
   input  wire [15:0] stackAddr,
   input  wire        stackWe,
   input  wire        stackRe,
   input  wire [7:0]  stackWdata,
   output logic [7:0] popData
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:2047];
   initial popData = 8'h00;
   // -----
   // Data SRAM
   // -----
   // Idle bus flips each cycle, so a stale byte never looks valid
   always @(posedge clk) begin
      if (stackWe)
         mem[stackAddr[10:0]] <= stackWdata;
      popData <= stackRe ? mem[stackAddr[10:0]] : ~popData;
   end
endmodule // csie_stack_ram

// [dv/csie_stack_irq_monitor.sv]
module csie_stack_irq_monitor (
   input wire        clk,
   input wire        resetn,
   input wire        opPush,
   input wire        opPop,
   input wire        opCall,
   input wire        opRet,
   input wire        opReti,
   input wire        opSei,
   input wire        opCli,
   input wire [7:0]  pushData,
   input wire [15:0] stackAddr,
   input wire        stackWe,
   input wire [7:0]  stackWdata,
   input wire        entryBusy,
   input wire        vectorValid,
   input wire        retPcValid,
   input wire [7:0]  irqFlags,
   input wire        globalEnable,
   input wire [15:0] stackPointer
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // -----
   // Properties
   // -----
   sp_reset_a: assert property ($rose(resetn) |->
      stackPointer == 16'h04FF && !globalEnable && irqFlags == 8'h00)
      else $error("bad state after reset");
   push_write_a: assert property (opPush && !entryBusy |->
      stackWe && stackAddr == stackPointer && stackWdata == pushData)
      else $error("push wrote wrong place");
   push_dec_a: assert property (opPush && !entryBusy |=>
      stackPointer == $past(stackPointer) - 16'h0001) else $error("push step wrong");
   pop_inc_a: assert property (opPop && !entryBusy |=>
      stackPointer == $past(stackPointer) + 16'h0001) else $error("pop step wrong");
   call_dec_a: assert property (opCall && !entryBusy |->
      ##5 stackPointer == $past(stackPointer, 5) - 16'h0002) else $error("call step wrong");
   ret_inc_a: assert property (opRet && !entryBusy |->
      ##5 stackPointer == $past(stackPointer, 5) + 16'h0002) else $error("ret step wrong");
   isr_exit_op_enable_a: assert property (opReti && !entryBusy |->
      ##[1:6] retPcValid ##[0:2] globalEnable) else $error("return did not enable");
   entry_gie_a: assert property (vectorValid |-> !globalEnable)
      else $error("enable left set on entry");
   cli_now_a: assert property (opCli && !entryBusy |=>
      (!globalEnable && !vectorValid) [*6]) else $error("taken after disable");
   sei_hold_a: assert property (opSei && !entryBusy |=>
      globalEnable && !entryBusy) else $error("entry right after enable");
   cover property (vectorValid);
   cover property (retPcValid && globalEnable);
   cover property (opPush && !entryBusy);
endmodule // csie_stack_irq_monitor

bind csie_stack_irq csie_stack_irq_monitor i_mon (.clk(clk), .resetn(resetn),
   .opPush(opPush), .opPop(opPop), .opCall(opCall), .opRet(opRet), .opReti(opReti),
   .opSei(opSei), .opCli(opCli), .pushData(pushData), .stackAddr(stackAddr),
   .stackWe(stackWe), .stackWdata(stackWdata), .entryBusy(entryBusy),
   .vectorValid(vectorValid), .retPcValid(retPcValid), .irqFlags(irqFlags),
   .globalEnable(globalEnable), .stackPointer(stackPointer));

// [dv/csie_stack_irq_bench.sv]
`include "csie_map.vh"
module csie_stack_irq_bench;
   timeunit 1ns;
   timeprecision 1ns;
   reg         clk, resetn, ioWrite, ioRead, sleeping, fuse;
   reg  [5:0]  ioAddr;
   reg  [7:0]  ioWdata, pushData, irqEvent, irqLevel, irqIsLevel, irqEnable, rd;
   reg  [6:0]  ops;
   reg  [15:0] curPc, sp0;
   reg  [31:0] r;
   reg  [15:0] pcs [0:2];
   reg  [7:0]  dat [0:3];
   wire [7:0]  ioRdata, popData, irqFlags, stackWdata;
   wire [15:0] stackAddr, vectorAddr, resetVector, retPc, stackPointer;
   wire        stackWe, stackRe, entryBusy, vectorValid, retPcValid, globalEnable;
   integer     seed, errors, nTests, i, n, n0;

   csie_stack_irq i_dut (.clk(clk), .resetn(resetn), .ioAddr(ioAddr), .ioWrite(ioWrite),
      .ioRead(ioRead), .ioWdata(ioWdata), .ioRdata(ioRdata), .opPush(ops[0]),
      .opPop(ops[1]), .opCall(ops[2]), .opRet(ops[3]), .opReti(ops[4]), .opSei(ops[5]),
      .opCli(ops[6]), .instrBoundary(1'b1), .sleeping(sleeping), .curPc(curPc),
      .pushData(pushData), .popData(popData), .irqEvent(irqEvent), .irqLevel(irqLevel),
      .irqIsLevel(irqIsLevel), .irqEnable(irqEnable), .appLockBitB(1'b0),
      .bootLockBitB(1'b0), .bootResetVectorFuse(fuse), .inBootSection(1'b0),
      .stackAddr(stackAddr), .stackWe(stackWe), .stackRe(stackRe), .stackWdata(stackWdata),
      .entryBusy(entryBusy), .vectorValid(vectorValid), .vectorAddr(vectorAddr),
      .resetVector(resetVector), .retPcValid(retPcValid), .retPc(retPc),
      .irqFlags(irqFlags), .globalEnable(globalEnable), .stackPointer(stackPointer));
   csie_stack_ram i_ram (.clk(clk), .stackAddr(stackAddr), .stackWe(stackWe),
      .stackRe(stackRe), .stackWdata(stackWdata), .popData(popData));

   always #5 clk = ~clk;
   // -----
   // Tasks
   // -----
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         nTests = nTests + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
         end
      end
   endtask
   task results;
      begin
         $display("comparisons %0d, mismatches %0d", nTests, errors);
         if (errors == 0 && nTests > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // Ops taken only while idle, so wait out any running sequence
   task idle;
      integer w;
      begin
         @(negedge clk);
         for (w = 0; w < 50 && entryBusy !== 1'b0; w = w + 1)
            @(negedge clk);
         @(posedge clk);
      end
   endtask
   task doOp(input integer k);
      begin
         idle;
         ops[k] <= 1'b1;
         @(posedge clk);
         ops <= 7'h00;
      end
   endtask
   task ioWr(input [5:0] a, input [7:0] d);
      begin
         @(posedge clk);
         ioAddr <= a;
         ioWdata <= d;
         ioWrite <= 1'b1;
         @(posedge clk);
         ioWrite <= 1'b0;
      end
   endtask
   task ioRd(input [5:0] a);
      begin
         @(posedge clk);
         ioAddr <= a;
         ioRead <= 1'b1;
         @(negedge clk);
         rd = ioRdata;
         @(posedge clk);
         ioRead <= 1'b0;
      end
   endtask
   task pulse(input [7:0] m);
      begin
         @(posedge clk);
         irqEvent <= m;
         @(posedge clk);
         irqEvent <= 8'h00;
      end
   endtask
   task waitFor(input sel);
      begin
         n = 0;
         @(negedge clk);
         while (((sel ? retPcValid : vectorValid) !== 1'b1) && n < 60) begin
            n = n + 1;
            @(negedge clk);
         end
         if (n == 60) begin
            errors = errors + 1;
            $display("unexpected at %0t: no answer", $time);
         end
      end
   endtask
   task quiet;
      repeat (8) begin
         @(negedge clk);
         chk({15'h0000, vectorValid}, 16'h0000);
      end
   endtask
   task entryChk(input [15:0] vec);
      begin
         chk(vectorAddr, vec);
         chk(stackPointer, sp0 - 16'h0002);
         chk({8'h00, i_ram.mem[sp0[10:0]]}, {8'h00, curPc[7:0]});
         chk({8'h00, i_ram.mem[sp0[10:0] - 11'h001]}, {8'h00, curPc[15:8]});
         chk({15'h0000, globalEnable}, 16'h0000);
      end
   endtask
   // -----
   // Sequence
   // -----
   initial begin
      {clk, resetn, ioWrite, ioRead, sleeping, fuse, ops, ioAddr, ioWdata} = 0;
      {pushData, irqEvent, irqLevel, irqIsLevel, irqEnable, curPc} = 0;
      seed = 32'hF8AE;
      errors = 0;
      nTests = 0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      ioRd(`CSIE_SP_LOW_ADDR);
      chk({8'h00, rd}, 16'h00FF);
      ioRd(`CSIE_SP_HIGH_ADDR);
      chk({8'h00, rd}, 16'h0004);
      chk({15'h0000, globalEnable}, 16'h0000);
      chk(resetVector, 16'h0000);
      fuse <= 1'b1;
      @(negedge clk);
      chk(resetVector, `CSIE_BOOT_START);
      ioWr(`CSIE_SP_HIGH_ADDR, 8'h03);
      ioWr(`CSIE_SP_LOW_ADDR, 8'h00);
      ioRd(`CSIE_SP_LOW_ADDR);
      chk({8'h00, rd}, 16'h0000);
      ioRd(`CSIE_SP_HIGH_ADDR);
      chk({8'h00, rd}, 16'h0003);
      $display("test registers done");
      sp0 = stackPointer;
      for (i = 0; i < 4; i = i + 1) begin
         r = $random(seed);
         dat[i] = r[7:0];
         pushData <= dat[i];
         doOp(0);
      end
      @(negedge clk);
      chk(stackPointer, sp0 - 16'h0004);
      for (i = 0; i < 4; i = i + 1)
         chk({8'h00, i_ram.mem[sp0[10:0] - i]}, {8'h00, dat[i]});
      for (i = 0; i < 4; i = i + 1)
         doOp(1);
      @(negedge clk);
      chk(stackPointer, sp0);
      for (i = 0; i < 3; i = i + 1) begin
         idle;
         r = $random(seed);
         pcs[i] = r[15:0];
         curPc <= pcs[i];
         doOp(2);
      end
      for (i = 2; i >= 0; i = i - 1) begin
         doOp(3);
         waitFor(1);
         chk(retPc, pcs[i]);
      end
      idle;
      chk(stackPointer, sp0);
      $display("test stack done");
      irqEnable <= 8'hFF;
      pulse(8'h24);
      @(negedge clk);
      chk({8'h00, irqFlags}, 16'h0024);
      sp0 = stackPointer;
      doOp(5);
      waitFor(0);
      entryChk(16'h0006);
      chk({8'h00, irqFlags}, 16'h0020);
      doOp(4);
      waitFor(1);
      chk(retPc, curPc);
      chk(stackPointer, sp0);
      waitFor(0);
      entryChk(16'h000C);
      $display("test priority done");
      ioWr(`CSIE_CORECTL_ADDR, 8'h02);
      for (i = 0; i < 2; i = i + 1) begin
         sleeping <= i[0];
         doOp(5);
         sp0 = stackPointer;
         pulse(8'h02);
         waitFor(0);
         entryChk(`CSIE_BOOT_START + 16'h0004);
         if (i == 0)
            n0 = n;
      end
      sleeping <= 1'b0;
      chk(16'(n - n0), 16'h0004);
      chk({15'h0000, n0 >= 4}, 16'h0001);
      $display("test timing done");
      irqIsLevel <= 8'h08;
      irqLevel <= 8'h08;
      repeat (2) @(posedge clk);
      irqLevel <= 8'h00;
      doOp(5);
      quiet;
      chk({8'h00, irqFlags}, 16'h0000);
      @(posedge clk);
      irqLevel <= 8'h08;
      sp0 = stackPointer;
      waitFor(0);
      entryChk(`CSIE_BOOT_START + 16'h0008);
      @(posedge clk);
      irqLevel <= 8'h00;
      doOp(5);
      @(posedge clk);
      ops[6] <= 1'b1;
      irqEvent <= 8'h01;
      @(posedge clk);
      ops <= 7'h00;
      irqEvent <= 8'h00;
      quiet;
      chk({8'h00, irqFlags}, 16'h0001);
      chk({15'h0000, globalEnable}, 16'h0000);
      ioWr(6'h36, 8'h01);
      @(negedge clk);
      chk({8'h00, irqFlags}, 16'h0000);
      $display("test level and disable done");
      results;
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #50000;
      errors = errors + 1;
      $display("unexpected at %0t: run hung", $time);
      results;
   end
endmodule // csie_stack_irq_bench
